// *** inc/phy_ctl_pkg.sv ***
package phy_ctl_pkg;

  localparam logic [7:0] IDX_DUPLEX_LED = 8'h0A;
  localparam logic [7:0] IDX_LINK_DROP = 8'h0B;
  localparam logic [7:0] IDX_LINK_STATUS = 8'h0C;

  localparam logic [15:0] DUPLEX_LED_RST = 16'h0100;
  localparam logic [15:0] LINK_DROP_RST = 16'h1000;

  localparam int BIT_EXT_FD = 5;
  localparam int BIT_ENH_LED = 4;
  localparam int BIT_ISOLATE = 3;
  localparam int BIT_IDLE_ERR = 2;
  localparam int BIT_ODD_DIS = 1;
  localparam int BIT_RMII_RXCLK = 0;
  localparam int BIT_EQ_ERR_BYP = 12;
  localparam int BIT_DESCR_DROP = 10;
  localparam int BIT_EQ_COEF_BYP = 9;
  localparam int FLD_FAST_DOWN_LSB = 0;
  localparam int FAST_DOWN_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic ieee_full_duplex;
    logic local_an_or_force100;
    logic partner_force100;
    logic activity;
    logic rx_idle;
    logic rx_symbol_err;
    logic eq_error;
    logic descr_lock_loss;
    logic [3:0] fast_down_events;
  } phy_status_t;

  typedef struct packed {
    logic full_duplex;
    logic link_led;
    logic mii_isolate;
    logic rx_idle_err;
    logic rx_ref_rx_clk;
    logic eq_error_used;
    logic eq_coef0_bypass;
    logic link_drop;
  } phy_ctrl_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] wr_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [15:0] duplex_led_isolate_control;
    logic [15:0] link_drop_equalizer_control;
    phy_ctrl_t ctrl;
  } regs_state_t;

  typedef struct packed {
    logic prev_en;
    logic odd;
    logic en;
    logic er;
  } nibble_state_t;

endpackage

// *** rtl/tx_nibble_extender.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_nibble_extender
  import phy_ctl_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic detect_en_in,
  input wire logic tx_en_in,
  input wire logic tx_er_in,
  output logic tx_en_out,
  output logic tx_er_out
);

  nibble_state_t st_r;
  nibble_state_t st_nxt;

  always_comb
  begin
    st_nxt = '0;
    if (!sys_rst_in)
    begin
      st_nxt.prev_en = tx_en_in;
      if (tx_en_in)
      begin
        st_nxt.en = 1'b1;
        st_nxt.er = tx_er_in;
        if (!st_r.prev_en)
        begin
          st_nxt.odd = 1'b1;
        end
        else
        begin
          st_nxt.odd = ~st_r.odd;
        end
      end
      else if (st_r.prev_en && st_r.odd && detect_en_in)
      begin
        // frame ended on an odd nibble: one more cycle flagged as error
        st_nxt.en = 1'b1;
        st_nxt.er = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end

  assign tx_en_out = st_r.en;
  assign tx_er_out = st_r.er;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_odd_extend: assert property (st_r.prev_en && st_r.odd && !tx_en_in
    && detect_en_in |=> tx_en_out && tx_er_out)
    else $error("odd nibble frame not extended with error");
  a_odd_off: assert property (!tx_en_in && !detect_en_in |=> !tx_en_out)
    else $error("frame extended while detection disabled");
  c_odd_extend: cover property (!tx_en_in && tx_en_out && tx_er_out);

endmodule // tx_nibble_extender
`default_nettype wire

// *** rtl/phy_link_controls.sv ***
`timescale 1ns/1ps
`default_nettype none
module phy_link_controls
  import phy_ctl_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire phy_status_t phy_status_in,
  output phy_ctrl_t phy_ctrl_out,
  input wire logic tx_en_in,
  input wire logic tx_er_in,
  output logic tx_en_out,
  output logic tx_er_out
);

  if (ADDR_W < 10)
  begin : g_addr_check
    $error("ADDR_W must be at least 10");
  end

  regs_state_t st_r;
  regs_state_t st_nxt;
  logic fd_res;
  logic do_wr;
  logic fast_drop;
  logic [7:0] rd_idx;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge for the 16-bit control registers

  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link decisions from the control fields

  always_comb
  begin
    fd_res = phy_status_in.ieee_full_duplex;
    if (st_r.duplex_led_isolate_control[BIT_EXT_FD]
        && phy_status_in.local_an_or_force100
        && phy_status_in.partner_force100)
    begin
      fd_res = 1'b1;
    end
  end

  always_comb
  begin
    fast_drop = |(phy_status_in.fast_down_events
      & st_r.link_drop_equalizer_control[FLD_FAST_DOWN_LSB +: FAST_DOWN_W]);
    if (st_r.link_drop_equalizer_control[BIT_DESCR_DROP]
        && phy_status_in.descr_lock_loss)
    begin
      fast_drop = 1'b1;
    end
  end

  assign rd_idx = s_axi_araddr_in[9:2];

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, registers and control outputs

  always_comb
  begin
    st_nxt = st_r;
    do_wr = 1'b0;
    if (sys_rst_in)
    begin
      st_nxt = '0;
      st_nxt.duplex_led_isolate_control = DUPLEX_LED_RST;
      st_nxt.link_drop_equalizer_control = LINK_DROP_RST;
    end
    else
    begin
      if (s_axi_awvalid_in && st_r.awready)
      begin
        st_nxt.aw_got = 1'b1;
        st_nxt.wr_idx = s_axi_awaddr_in[9:2];
      end
      if (s_axi_wvalid_in && st_r.wready)
      begin
        st_nxt.w_got = 1'b1;
        st_nxt.wdata = s_axi_wdata_in;
        st_nxt.wstrb = s_axi_wstrb_in;
      end
      if (st_r.bvalid && s_axi_bready_in)
      begin
        st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
      begin
        do_wr = 1'b1;
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = RESP_OKAY;
        unique case (st_r.wr_idx)
          IDX_DUPLEX_LED:
          begin
            st_nxt.duplex_led_isolate_control = merge16(
              st_r.duplex_led_isolate_control, st_r.wdata,
              st_r.wstrb);
          end
          IDX_LINK_DROP:
          begin
            st_nxt.link_drop_equalizer_control = merge16(
              st_r.link_drop_equalizer_control, st_r.wdata,
              st_r.wstrb);
          end
          IDX_LINK_STATUS:
          begin
            // read-only: write ignored
            st_nxt.bresp = RESP_OKAY;
          end
          default:
          begin
            st_nxt.bresp = RESP_SLVERR;
          end
        endcase
      end
      if (st_r.rvalid && s_axi_rready_in)
      begin
        st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && st_r.arready)
      begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rresp = RESP_OKAY;
        unique case (rd_idx)
          IDX_DUPLEX_LED:
          begin
            st_nxt.rdata = {16'h0000, st_r.duplex_led_isolate_control};
          end
          IDX_LINK_DROP:
          begin
            st_nxt.rdata = {16'h0000, st_r.link_drop_equalizer_control};
          end
          IDX_LINK_STATUS:
          begin
            st_nxt.rdata = {24'h000000, st_r.ctrl};
          end
          default:
          begin
            st_nxt.rdata = 32'h00000000;
            st_nxt.rresp = RESP_SLVERR;
          end
        endcase
      end
      st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;

      // control outputs follow the fields one clock later
      st_nxt.ctrl.full_duplex = fd_res;
      if (st_r.duplex_led_isolate_control[BIT_ENH_LED])
      begin
        // lit only on a 100 full duplex link, no activity blink
        st_nxt.ctrl.link_led = phy_status_in.link_up
          && phy_status_in.speed_100 && fd_res;
      end
      else
      begin
        st_nxt.ctrl.link_led = phy_status_in.link_up
          && !phy_status_in.activity;
      end
      st_nxt.ctrl.mii_isolate =
        st_r.duplex_led_isolate_control[BIT_ISOLATE]
        && phy_status_in.link_up
        && (!phy_status_in.speed_100 || !fd_res);
      st_nxt.ctrl.rx_idle_err =
        st_r.duplex_led_isolate_control[BIT_IDLE_ERR]
        && phy_status_in.rx_idle && phy_status_in.rx_symbol_err;
      st_nxt.ctrl.rx_ref_rx_clk =
        st_r.duplex_led_isolate_control[BIT_RMII_RXCLK];
      st_nxt.ctrl.eq_error_used = phy_status_in.eq_error
        && !st_r.link_drop_equalizer_control[BIT_EQ_ERR_BYP];
      st_nxt.ctrl.eq_coef0_bypass =
        st_r.link_drop_equalizer_control[BIT_EQ_COEF_BYP];
      st_nxt.ctrl.link_drop = fast_drop;
    end
  end

  always_ff @(posedge clock_in)
  begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit odd-nibble stage

  tx_nibble_extender u_tx_nibble (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .detect_en_in(!st_r.duplex_led_isolate_control[BIT_ODD_DIS]),
    .tx_en_in(tx_en_in),
    .tx_er_in(tx_er_in),
    .tx_en_out(tx_en_out),
    .tx_er_out(tx_er_out)
  );

  assign s_axi_awready_out = st_r.awready;
  assign s_axi_wready_out = st_r.wready;
  assign s_axi_bvalid_out = st_r.bvalid;
  assign s_axi_bresp_out = st_r.bresp;
  assign s_axi_arready_out = st_r.arready;
  assign s_axi_rvalid_out = st_r.rvalid;
  assign s_axi_rresp_out = st_r.rresp;
  assign s_axi_rdata_out = st_r.rdata;
  assign phy_ctrl_out = st_r.ctrl;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_fd_forced: assert property (
    st_r.duplex_led_isolate_control[BIT_EXT_FD]
    && phy_status_in.local_an_or_force100 && phy_status_in.partner_force100
    |=> phy_ctrl_out.full_duplex)
    else $error("extended full duplex not forced");

  a_fd_standard: assert property (
    !st_r.duplex_led_isolate_control[BIT_EXT_FD]
    |=> phy_ctrl_out.full_duplex == $past(phy_status_in.ieee_full_duplex))
    else $error("duplex differs from standard resolution");

  a_led_enhanced: assert property (
    st_r.duplex_led_isolate_control[BIT_ENH_LED]
    && !(phy_status_in.speed_100 && fd_res)
    |=> !phy_ctrl_out.link_led)
    else $error("enhanced LED lit without 100 full duplex link");

  a_led_no_blink: assert property (
    st_r.duplex_led_isolate_control[BIT_ENH_LED] && phy_status_in.link_up
    && phy_status_in.speed_100 && fd_res && phy_status_in.activity
    |=> phy_ctrl_out.link_led)
    else $error("enhanced LED blinked on activity");

  a_isolate_mii: assert property (
    st_r.duplex_led_isolate_control[BIT_ISOLATE] && phy_status_in.link_up
    && !phy_status_in.speed_100 |=> phy_ctrl_out.mii_isolate)
    else $error("MII not isolated on 10 link");

  a_isolate_off: assert property (
    !st_r.duplex_led_isolate_control[BIT_ISOLATE]
    |=> !phy_ctrl_out.mii_isolate)
    else $error("MII isolated with isolation disabled");

  a_idle_err: assert property (
    phy_status_in.rx_idle && phy_status_in.rx_symbol_err
    |=> phy_ctrl_out.rx_idle_err
        == $past(st_r.duplex_led_isolate_control[BIT_IDLE_ERR]))
    else $error("idle symbol error detection wrong");

  a_rx_ref_sel: assert property (
    ##1 phy_ctrl_out.rx_ref_rx_clk
    == $past(st_r.duplex_led_isolate_control[BIT_RMII_RXCLK]))
    else $error("RMII receive reference select wrong");

  a_eq_err_byp: assert property (
    st_r.link_drop_equalizer_control[BIT_EQ_ERR_BYP]
    |=> !phy_ctrl_out.eq_error_used)
    else $error("equalizer error used while bypassed");

  a_descr_drop: assert property (
    st_r.link_drop_equalizer_control[BIT_DESCR_DROP]
    && phy_status_in.descr_lock_loss |=> phy_ctrl_out.link_drop)
    else $error("descrambler lock loss did not drop link");

  a_drop_or: assert property (
    |(phy_status_in.fast_down_events
      & st_r.link_drop_equalizer_control[FLD_FAST_DOWN_LSB +: FAST_DOWN_W])
    |=> phy_ctrl_out.link_drop)
    else $error("fast link down not ORed");

  a_drop_none: assert property (
    !(|(phy_status_in.fast_down_events
      & st_r.link_drop_equalizer_control[FLD_FAST_DOWN_LSB +: FAST_DOWN_W]))
    && !(st_r.link_drop_equalizer_control[BIT_DESCR_DROP]
      && phy_status_in.descr_lock_loss)
    |=> !phy_ctrl_out.link_drop)
    else $error("link dropped with no enabled condition");

  a_eq_coef: assert property (
    st_r.link_drop_equalizer_control[BIT_EQ_COEF_BYP]
    |=> phy_ctrl_out.eq_coef0_bypass)
    else $error("coefficient bypass not applied");

  a_write_back: assert property (
    do_wr && st_r.wr_idx == IDX_LINK_DROP && st_r.wstrb[1:0] == 2'h3
    |=> st_r.link_drop_equalizer_control == $past(st_r.wdata[15:0])
        && s_axi_bvalid_out)
    else $error("register write not stored");

  a_bresp_hold: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
    && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");

  c_write_done: cover property (do_wr ##[1:4] s_axi_bvalid_out);
  c_read_done: cover property (s_axi_rvalid_out && s_axi_rready_in);
  c_link_drop: cover property (phy_ctrl_out.link_drop);
  c_isolate: cover property (phy_ctrl_out.mii_isolate);

endmodule // phy_link_controls
`default_nettype wire

// *** verif/mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_model
(
  input wire logic clock_in,
  output logic tx_en_out,
  output logic tx_er_out
);
  initial
  begin
    tx_en_out = 1'b0;
    tx_er_out = 1'b0;
  end
  // one frame of n nibbles, then an idle gap
  task automatic send(input int n);
    begin
      @(posedge clock_in);
      tx_en_out <= 1'b1;
      repeat (n) @(posedge clock_in);
      tx_en_out <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
  endtask
endmodule // mac_model
`default_nettype wire

// *** verif/phy_duplex_link_drop_controls_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module phy_duplex_link_drop_controls_test
  import phy_ctl_pkg::*;
;
  localparam logic [11:0] A2 = 12'({IDX_DUPLEX_LED, 2'h0});
  localparam logic [11:0] A3 = 12'({IDX_LINK_DROP, 2'h0});
  // each entry: duplex_led word, link_drop word, status
  localparam logic [47:0] CS [15] = '{
    48'h0020_1000_36E0, 48'h0000_1000_37E0, 48'h0010_1000_39E0,
    48'h0010_1000_28E0, 48'h0008_1000_30E0, 48'h0008_1000_28E0,
    48'h0008_1000_38E0, 48'h0005_1000_38E0, 48'h0000_0000_38E0,
    48'h0000_1200_38E0, 48'h0000_1400_38F0, 48'h0000_1000_38F0,
    48'h0000_1408_38E8, 48'h0000_1401_38E2, 48'h0000_100F_38E1};
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [11:0] aw_a = 12'h000, ar_a = 12'h000;
  logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
  logic [31:0] w_d = 32'h0, r_d;
  logic [3:0] w_s = 4'h3;
  logic aw_r, w_r, b_v, ar_r, r_v, m_en, m_er, t_en, t_er, last_er;
  logic [1:0] b_resp, r_resp;
  logic [15:0] c2, c3;
  phy_status_t st = '0;
  phy_ctrl_t ctrl;
  int err_count = 0;
  int num_checks = 0;
  int len = 0;

  always #5 clock_in = ~clock_in;

  phy_link_controls i_dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_r), .s_axi_bresp_out(b_resp),
    .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_rdy),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_v),
    .s_axi_rready_in(r_rdy), .phy_status_in(st), .phy_ctrl_out(ctrl),
    .tx_en_in(m_en), .tx_er_in(m_er), .tx_en_out(t_en), .tx_er_out(t_er));

  mac_model i_mac (.clock_in(clock_in), .tx_en_out(m_en), .tx_er_out(m_er));

  always @(posedge clock_in)
    if (t_en === 1'b1)
    begin
      len <= len + 1;
      last_er <= t_er;
    end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      num_checks++;
      if (g !== e)
      begin
        err_count++;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  task automatic chk_ctrl(input phy_ctrl_t g, input phy_ctrl_t e);
    begin
      chk({24'h0, g}, {24'h0, e});
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw;
    logic w;
    begin
      @(posedge clock_in);
      aw_a <= a;
      w_d <= d;
      w_s <= s;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w))
      begin
        @(posedge clock_in);
        if (!aw && aw_r === 1'b1)
        begin
          aw = 1'b1;
          aw_v <= 1'b0;
        end
        if (!w && w_r === 1'b1)
        begin
          w = 1'b1;
          w_v <= 1'b0;
        end
      end
      do @(posedge clock_in); while (b_v !== 1'b1);
      b_rdy <= 1'b0;
      chk({30'h0, b_resp}, {30'h0, er});
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    begin
      @(posedge clock_in);
      ar_a <= a;
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      do @(posedge clock_in); while (ar_r !== 1'b1);
      ar_v <= 1'b0;
      do @(posedge clock_in); while (r_v !== 1'b1);
      r_rdy <= 1'b0;
      chk(r_d, ed);
      chk({30'h0, r_resp}, {30'h0, er});
    end
  endtask

  task automatic tx(input int n, input int l, input logic e);
    int l0;
    begin
      l0 = len;
      i_mac.send(n);
      chk(len - l0, l);
      chk({31'h0, last_er}, {31'h0, e});
    end
  endtask

  function automatic phy_ctrl_t model(input logic [15:0] d, input logic [15:0] q,
                                      input phy_status_t s);
    phy_ctrl_t e;
    logic fd;
    begin
      fd = s.ieee_full_duplex
        | (d[5] & s.local_an_or_force100 & s.partner_force100);
      e.full_duplex = fd;
      e.link_led = d[4] ? (s.link_up & s.speed_100 & fd)
                        : (s.link_up & ~s.activity);
      e.mii_isolate = d[3] & s.link_up & (~s.speed_100 | ~fd);
      e.rx_idle_err = d[2] & s.rx_idle & s.rx_symbol_err;
      e.rx_ref_rx_clk = d[0];
      e.eq_error_used = ~q[12] & s.eq_error;
      e.eq_coef0_bypass = q[9];
      e.link_drop = (q[10] & s.descr_lock_loss)
                    | (|(q[3:0] & s.fast_down_events));
      return e;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    st <= phy_status_t'(14'h20E0);
    repeat (2) @(posedge clock_in);
    rd(A2, 32'h0000_0100, RESP_OKAY);
    rd(A3, 32'h0000_1000, RESP_OKAY);
    chk_ctrl(ctrl, model(16'h0100, 16'h1000, st));
    wr(12'h030, 32'h0000_FFFF, 4'h3, RESP_OKAY);
    rd(12'h030, {24'h0, model(16'h0100, 16'h1000, st)}, RESP_OKAY);
    wr(12'h040, 32'h0000_FFFF, 4'h3, RESP_SLVERR);
    rd(12'h040, 32'h0, RESP_SLVERR);
    wr(A2, 32'hFFFF_0123, 4'hF, RESP_OKAY);
    wr(A2, 32'h0000_FF55, 4'h1, RESP_OKAY);
    rd(A2, 32'h0000_0155, RESP_OKAY);
    for (int i = 0; i < 15; i++)
    begin
      c2 = CS[i][47:32];
      c3 = CS[i][31:16];
      wr(A2, {16'h0, c2}, 4'h3, RESP_OKAY);
      wr(A3, {16'h0, c3}, 4'h3, RESP_OKAY);
      st <= phy_status_t'(CS[i][13:0]);
      repeat (3) @(posedge clock_in);
      chk_ctrl(ctrl, model(c2, c3, st));
      rd(A3, {16'h0, c3}, RESP_OKAY);
    end
    wr(A2, 32'h0, 4'h3, RESP_OKAY);
    tx(3, 4, 1'b1);
    tx(1, 2, 1'b1);
    tx(4, 4, 1'b0);
    wr(A2, 32'h0000_0002, 4'h3, RESP_OKAY);
    tx(3, 3, 1'b0);
    wrap_up;
  end

  initial
  begin
    repeat (20000) @(posedge clock_in);
    err_count++;
    wrap_up;
  end
endmodule // phy_duplex_link_drop_controls_test
`default_nettype wire
